/* File: logic/srfsd_top.sv */
// Serial register port, 64-byte data queue with serializer, pattern recognizer.
// Assumes host SCK well below core_clk/8 and modem clock from the demodulator.
//
// What this block does
// - Register port is a slave only, mode 0, full duplex.
// - Sample MOSI on SCK rise, drive MISO on SCK fall.
// - Frame opens on NSS falling; MISO released while NSS is high.
// - First byte: write flag then 7-bit address, MSB first.
// - Data bytes travel MSB first, MOSI for writes, MISO for reads.
// - Non-queue address increments after each data byte in a frame.
// - Queue address stays fixed; data bytes hit the queue, except writes in receive and reads in transmit.
// - NSS rising ends a frame; next frame restarts with an address.
// - A write returns the register's old value on MISO.
// - Queue is eight bits wide and 64 entries deep.
// - Serializer sends queue bytes MSB first; gathers received bits into bytes.
// - Empty flag high only with no bytes; refreshed at NSS fall.
// - Full flag high exactly when all 64 entries hold bytes.
// - Push into full queue sets overrun, drops byte; writing 1 clears both.
// - Frame-sent flag rises after the serializer's last bit.
// - Level flag re-evaluated only on queue reads or writes.
// - After full the level flag freezes until the queue empties.
// - Queue cleared or kept on mode changes per the mode table.
// - Recognizer runs only when enabled; continuous mode needs bit sync.
// - Received bit stream compared with programmed pattern, first bit to MSB.
// - Match flag clears on leaving receive or queue emptying.
// - Pattern is one to eight bytes of a 64-bit value; no zero bytes.
`timescale 1ns/100ps

module srfsd_top
    import srfsd_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic spi_sck,
    input wire logic spi_nss,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire srfsd_mode_t op_mode,
    input wire logic packet_mode,
    input wire logic bitsync_enable,
    input wire logic demod_clk,
    input wire logic demod_data,
    output logic mod_data,
    output srfsd_qstat_t queue_status,
    output logic frame_sent_flag,
    output logic pattern_match_flag
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic pattern_hit(input logic [63:0] hist, input logic [2:0] len,
                                         input logic [63:0] value);
        logic [5:0] sh;
        logic [63:0] mask;
        sh = 6'd56 - {len, 3'b000};
        mask = 64'hffff_ffff_ffff_ffff >> sh;
        return ((hist ^ (value >> sh)) & mask) == 64'h0000_0000_0000_0000;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers: nss, sck, mosi, demod clock, demod data
    // ----------------------------------------------------------------
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] pin;
    logic [4:0] pin_d;
    wire [4:0] pin_in = {demod_data, demod_clk, spi_mosi, spi_sck, spi_nss};
    // Accept a change only once stages two and three agree
    wire [4:0] next_pin = (sync3 & ~(sync2 ^ sync3)) | (pin & (sync2 ^ sync3));

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sync1 <= 5'h01;
            sync2 <= 5'h01;
            sync3 <= 5'h01;
            pin <= 5'h01;
            pin_d <= 5'h01;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            pin <= next_pin;
            pin_d <= pin;
        end
    end

    wire nss_fall = pin_d[0] & ~pin[0];
    wire nss_rise = ~pin_d[0] & pin[0];
    wire sck_rise = ~pin_d[1] & pin[1];
    wire sck_fall = pin_d[1] & ~pin[1];
    wire mosi_bit = pin[2];
    wire demod_rise = ~pin_d[3] & pin[3];
    wire demod_bit = pin[4];

    // ----------------------------------------------------------------
    // Register storage and configuration decode
    // ----------------------------------------------------------------
    logic [7:0] regs [0:127];
    logic [63:0] pattern_value_field;
    wire [7:0] pattern_config_reg = regs[PATTERN_CONFIG_ADDR];
    wire [7:0] queue_threshold_reg = regs[QUEUE_THRESHOLD_ADDR];
    wire [2:0] pattern_length_field = pattern_config_reg[PATTERN_LENGTH_LSB +: 3];
    wire pattern_detect_enable = pattern_config_reg[PATTERN_ENABLE_BIT];
    wire [5:0] queue_level_threshold = queue_threshold_reg[QUEUE_THRESHOLD_LSB +: 6];

    for (genvar i = 0; i < 8; i++) begin : g_pattern
        // First pattern byte lands in the top byte of the compare value
        assign pattern_value_field[63 - 8 * i -: 8] = regs[PATTERN_FIRST_BYTE_ADDR + 7'(i)];
    end

    // ----------------------------------------------------------------
    // Serial register port
    // ----------------------------------------------------------------
    srfsd_spi_state_t spi_state;
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic [7:0] tx_sh;
    logic [6:0] addr;
    logic wnr;
    logic load_pend;

    logic [7:0] queue [0:QUEUE_DEPTH-1];
    logic [QUEUE_AW-1:0] rd_ptr;
    logic [QUEUE_AW-1:0] wr_ptr;
    logic [6:0] count;
    logic overrun;
    logic level;
    logic level_frozen;
    logic empty;

    wire [7:0] byte_in = {rx_sh, mosi_bit};
    wire byte_done = sck_rise && spi_state != SPI_IDLE && bit_cnt == 3'd7;
    wire wr_stb = byte_done && spi_state == SPI_DATA && wnr;
    wire at_fifo = addr == FIFO_ADDR;
    wire at_flags = addr == FLAGS_ADDR;
    wire spi_load = sck_fall && spi_state == SPI_DATA && load_pend;
    wire full = count == QUEUE_FULL_COUNT;
    wire [7:0] flags_byte = {2'b00, level, overrun, frame_sent_flag, pattern_match_flag,
                             full, empty};
    // old value out: read value sampled before the byte's write lands
    wire [7:0] rd_val = at_fifo ? queue[rd_ptr] : (at_flags ? flags_byte : regs[addr]);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            spi_state <= SPI_IDLE;
            bit_cnt <= 3'd0;
            rx_sh <= 7'h00;
            tx_sh <= 8'h00;
            addr <= 7'h00;
            wnr <= 1'b0;
            load_pend <= 1'b0;
            spi_miso <= 1'b0;
        // frame end: NSS high aborts any partial byte
        end else if (nss_rise) begin
            spi_state <= SPI_IDLE;
            load_pend <= 1'b0;
        end else if (nss_fall) begin
            spi_state <= SPI_ADDR;
            bit_cnt <= 3'd0;
            tx_sh <= 8'h00;
            load_pend <= 1'b0;
            spi_miso <= 1'b0;
        end else if (spi_state != SPI_IDLE) begin
            if (sck_rise) begin
                rx_sh <= byte_in[6:0];
                bit_cnt <= bit_cnt + 3'd1;
                if (byte_done) begin
                    load_pend <= 1'b1;
                    if (spi_state == SPI_ADDR) begin
                        wnr <= byte_in[7];
                        addr <= byte_in[6:0];
                        spi_state <= SPI_DATA;
                    end else if (!at_fifo) begin
                        addr <= addr + 7'd1;
                    end
                end
            end
            // drive MISO on fall; MSB first
            if (sck_fall) begin
                if (spi_load) begin
                    load_pend <= 1'b0;
                    spi_miso <= rd_val[7];
                    tx_sh <= {rd_val[6:0], 1'b0};
                end else begin
                    spi_miso <= tx_sh[7];
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
            end
        end
    end

    assign spi_miso_oe = ~pin[0];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < 128; i++) begin
                regs[i] <= REG_RESET;
            end
            regs[PATTERN_CONFIG_ADDR] <= PATTERN_CONFIG_RESET;
            regs[QUEUE_THRESHOLD_ADDR] <= QUEUE_THRESHOLD_RESET;
        end else if (wr_stb && !at_fifo && !at_flags) begin
            regs[addr] <= byte_in;
        end
    end

    // ----------------------------------------------------------------
    // Mode changes
    // ----------------------------------------------------------------
    srfsd_mode_t mode_d;
    wire mode_chg = op_mode != mode_d;
    wire in_rx = op_mode == MODE_RX;
    wire in_tx = op_mode == MODE_TX;
    // clear on idle-to-receive, receive-to-transmit, leaving transmit
    wire mode_clear = mode_chg && ((in_rx && (mode_d == MODE_SLEEP || mode_d == MODE_STDBY))
                      || (in_tx && mode_d == MODE_RX) || mode_d == MODE_TX);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mode_d <= MODE_SLEEP;
        end else begin
            mode_d <= op_mode;
        end
    end

    // ----------------------------------------------------------------
    // Serializer
    // ----------------------------------------------------------------
    logic [7:0] ser_byte;
    logic [2:0] ser_cnt;
    logic ser_busy;
    logic [15:0] baud;
    logic [7:0] rx_byte;
    logic [2:0] rx_cnt;
    logic rx_payload;
    logic [63:0] rx_hist;
    logic rx_new;
    logic pattern_set;

    wire baud_tick = baud == 16'(BIT_CYCLES - 1);
    // pull next byte when idle in packet transmit
    wire ser_pop = in_tx && packet_mode && !ser_busy && !empty && !mode_clear;
    wire ser_last = ser_busy && baud_tick && ser_cnt == 3'd7;
    wire rx_push = in_rx && packet_mode && rx_payload && demod_rise && rx_cnt == 3'd7;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ser_byte <= 8'h00;
            ser_cnt <= 3'd0;
            ser_busy <= 1'b0;
            baud <= 16'h0000;
            mod_data <= 1'b0;
            frame_sent_flag <= 1'b0;
        end else begin
            baud <= (baud_tick || !ser_busy) ? 16'h0000 : baud + 16'h0001;
            if (ser_pop) begin
                ser_byte <= queue[rd_ptr];
                ser_busy <= 1'b1;
                ser_cnt <= 3'd0;
                mod_data <= queue[rd_ptr][7];
                frame_sent_flag <= 1'b0;
            // MSB first at the bit rate
            end else if (ser_busy && baud_tick) begin
                ser_byte <= {ser_byte[6:0], 1'b0};
                // Hold the last bit so no short filler bit precedes the next byte
                if (!ser_last) begin
                    mod_data <= ser_byte[6];
                end
                ser_cnt <= ser_cnt + 3'd1;
                ser_busy <= !ser_last;
            end
            // sent once last bit is out and nothing follows
            if (ser_last && empty) begin
                frame_sent_flag <= 1'b1;
            end else if (!in_tx) begin
                frame_sent_flag <= 1'b0;
                ser_busy <= 1'b0;
            end
        end
    end

    // rolling history, newest bit in the LSB
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_hist <= 64'h0000_0000_0000_0000;
            rx_new <= 1'b0;
            rx_byte <= 8'h00;
            rx_cnt <= 3'd0;
            rx_payload <= 1'b0;
        end else begin
            rx_new <= demod_rise && in_rx;
            if (demod_rise && in_rx) begin
                rx_hist <= {rx_hist[62:0], demod_bit};
            end
            if (!in_rx) begin
                rx_payload <= 1'b0;
                rx_cnt <= 3'd0;
            end else if (pattern_set) begin
                rx_payload <= 1'b1;
                rx_cnt <= 3'd0;
            end else if (rx_payload && demod_rise) begin
                rx_byte <= {rx_byte[6:0], demod_bit};
                rx_cnt <= rx_cnt + 3'd1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pattern recognizer
    // ----------------------------------------------------------------
    // bit sync needed only outside packet operation
    wire detect_on = pattern_detect_enable && (packet_mode || bitsync_enable);
    // compare length from config; one to eight bytes
    assign pattern_set = rx_new && detect_on && !rx_payload
                         && pattern_hit(rx_hist, pattern_length_field, pattern_value_field);

    // ----------------------------------------------------------------
    // Data queue
    // ----------------------------------------------------------------
    // queue address writes append; reads pop at byte load
    wire host_push = wr_stb && at_fifo && !in_rx;
    wire spi_pop = spi_load && !wnr && at_fifo && !in_tx && !empty;
    wire push_req = host_push || rx_push;
    wire push_ok = push_req && !full;
    wire pop = spi_pop || ser_pop;
    // write one to clear overrun and the queue
    wire ovr_clear = wr_stb && at_flags && byte_in[FLAG_OVERRUN_BIT];
    wire queue_clear = mode_clear || ovr_clear;
    wire [6:0] next_count = count + {6'd0, push_ok} - {6'd0, pop};
    wire went_empty = pop && next_count == 7'd0;

    always_ff @(posedge core_clk) begin
        if (push_ok) begin
            queue[wr_ptr] <= rx_push ? {rx_byte[6:0], demod_bit} : byte_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || queue_clear) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= 7'd0;
            level <= 1'b0;
            level_frozen <= 1'b0;
        end else begin
            rd_ptr <= rd_ptr + QUEUE_AW'(pop);
            wr_ptr <= wr_ptr + QUEUE_AW'(push_ok);
            count <= next_count;
            // level moves only on queue traffic
            if ((push_ok || pop) && !level_frozen) begin
                level <= next_count > {1'b0, queue_level_threshold};
            end
            if (next_count == QUEUE_FULL_COUNT) begin
                level_frozen <= 1'b1;
            end else if (next_count == 7'd0) begin
                level_frozen <= 1'b0;
                level <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            overrun <= 1'b0;
            empty <= 1'b1;
            pattern_match_flag <= 1'b0;
        end else begin
            // drop and flag; a new overrun beats the clear
            if (push_req && full) begin
                overrun <= 1'b1;
            end else if (ovr_clear) begin
                overrun <= 1'b0;
            end
            // refresh on NSS fall and on queue changes
            if (queue_clear) begin
                empty <= 1'b1;
            end else if (nss_fall || push_ok || pop) begin
                empty <= next_count == 7'd0;
            end
            // cleared on leaving receive or emptying; set wins
            if (pattern_set) begin
                pattern_match_flag <= 1'b1;
            end else if (!in_rx || went_empty) begin
                pattern_match_flag <= 1'b0;
            end
        end
    end

    assign queue_status = '{queue_empty_flag: empty, queue_full_flag: full,
                            queue_overrun_flag: overrun, queue_level_flag: level};

endmodule // srfsd_top

/* File: logic/srfsd_pkg.sv */
// Constants, register map and types for the radio data-processing front end.
// Assumes a single 25 MHz core clock; all pins arrive asynchronously.
package srfsd_pkg;

    // ----------------------------------------------------------------
    // Clock and modem timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int BIT_RATE_BPS = 4800;
    localparam int BIT_CYCLES_DFLT = CLK_HZ / BIT_RATE_BPS;

    // ----------------------------------------------------------------
    // Queue geometry
    // ----------------------------------------------------------------
    localparam int QUEUE_DEPTH = 64;
    localparam int QUEUE_AW = 6;
    localparam logic [6:0] QUEUE_FULL_COUNT = 7'h40;

    // ----------------------------------------------------------------
    // Register addresses (7-bit serial address space)
    // ----------------------------------------------------------------
    localparam logic [6:0] FIFO_ADDR = 7'h00;
    localparam logic [6:0] PATTERN_CONFIG_ADDR = 7'h27;
    localparam logic [6:0] PATTERN_FIRST_BYTE_ADDR = 7'h28;
    localparam logic [6:0] QUEUE_THRESHOLD_ADDR = 7'h35;
    localparam logic [6:0] FLAGS_ADDR = 7'h3e;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int PATTERN_ENABLE_BIT = 4;
    localparam int PATTERN_LENGTH_LSB = 0;
    localparam int QUEUE_THRESHOLD_LSB = 0;
    localparam int FLAG_OVERRUN_BIT = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] PATTERN_CONFIG_RESET = 8'h13;
    localparam logic [7:0] QUEUE_THRESHOLD_RESET = 8'h0f;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_STDBY,
        MODE_TX,
        MODE_RX
    } srfsd_mode_t;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_ADDR,
        SPI_DATA
    } srfsd_spi_state_t;

    typedef struct packed {
        logic queue_empty_flag;
        logic queue_full_flag;
        logic queue_overrun_flag;
        logic queue_level_flag;
    } srfsd_qstat_t;

endpackage

/* File: sim/srfsd_asserts.sv */
// Port-level checks for the front end.
// Assumes one core clock domain.
`timescale 1ns/100ps

module srfsd_asserts
    import srfsd_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic spi_sck,
    input wire logic spi_nss,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire srfsd_mode_t op_mode,
    input wire logic packet_mode,
    input wire logic bitsync_enable,
    input wire logic demod_clk,
    input wire logic demod_data,
    input wire logic mod_data,
    input wire srfsd_qstat_t queue_status,
    input wire logic frame_sent_flag,
    input wire logic pattern_match_flag
);
    // ------
    // Helpers
    // ------
    wire q_full = queue_status.queue_full_flag;
    wire q_empty = queue_status.queue_empty_flag;
    wire q_level = queue_status.queue_level_flag;
    wire q_ovr = queue_status.queue_overrun_flag;
    logic prev_mod;
    logic [15:0] hold_cnt;

    // Saturates so a long idle cannot wrap into a false short bit
    always_ff @(posedge core_clk) begin
        prev_mod <= mod_data;
        if (!rstn || mod_data != prev_mod) begin
            hold_cnt <= 16'h0000;
        end else if (hold_cnt != 16'hffff) begin
            hold_cnt <= hold_cnt + 16'h0001;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // ------
    // Assertions
    // ------
    chk_oe_idle: assert property (spi_nss [*8] |-> !spi_miso_oe)
        else $error("oe idle");
    chk_oe_frame: assert property (!spi_nss [*8] |-> spi_miso_oe)
        else $error("oe frame");
    chk_miso_fall: assert property (spi_sck [*8] |-> $stable(spi_miso))
        else $error("miso edge");
    chk_flag_excl: assert property (!(q_empty && q_full))
        else $error("empty full");
    chk_overrun_full: assert property ($rose(q_ovr) |-> $past(q_full))
        else $error("overrun");
    chk_level_frozen: assert property (q_full && $past(q_full) |-> $stable(q_level))
        else $error("level full");
    chk_sent_tx: assert property (op_mode != MODE_TX [*3] |-> !frame_sent_flag)
        else $error("sent flag");
    chk_match_rx: assert property (op_mode != MODE_RX [*3] |-> !pattern_match_flag)
        else $error("match rx");
    chk_match_en: assert property ($rose(pattern_match_flag) |->
        op_mode == MODE_RX && (packet_mode || bitsync_enable))
        else $error("match off");
    chk_bit_period: assert property (op_mode == MODE_TX && mod_data != prev_mod
        |-> hold_cnt >= 16'(BIT_CYCLES - 1))
        else $error("bit short");

    cov_match: cover property ($rose(pattern_match_flag));
    cov_overrun: cover property ($rose(q_ovr));
    cov_sent: cover property ($rose(frame_sent_flag));
    cov_full: cover property ($rose(q_full));
endmodule // srfsd_asserts

bind srfsd_top srfsd_asserts #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.*);

/* File: sim/srfsd_host.sv */
// Serial master model for the host.
// Assumes core_clk paces it, ten cycles per half bit.
`timescale 1ns/100ps

module srfsd_host (
    input wire logic core_clk,
    input wire logic spi_miso_w,
    output logic spi_sck = 1'b0,
    output logic spi_nss = 1'b1,
    output logic spi_mosi = 1'b0
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // ------
    // Frame engine
    // ------
    // select low, one address, data, select high
    task automatic frame(input logic wnr, input logic [6:0] addr, input int n);
        logic [7:0] b, r;
        rx_q.delete();
        spi_nss <= 1'b0;
        tick(10);
        for (int i = 0; i <= n; i++) begin
            b = (i == 0) ? {wnr, addr} : (wnr ? tx_q.pop_front() : 8'(~i));
            for (int k = 7; k >= 0; k--) begin
                // MOSI moves at SCK fall, MISO taken at rise
                spi_mosi <= b[k];
                tick(10);
                spi_sck <= 1'b1;
                r[k] = spi_miso_w;
                tick(10);
                spi_sck <= 1'b0;
            end
            if (i != 0) begin
                rx_q.push_back(r);
            end
        end
        tick(10);
        spi_nss <= 1'b1;
        // Released line shows no stale level
        spi_mosi <= ~spi_mosi;
        tick(10);
    endtask
endmodule // srfsd_host

/* File: sim/srfsd_tb_top.sv */
// Self-checking bench for the front end.
// Assumes srfsd_host as partner and the bound checker.
`timescale 1ns/100ps

module srfsd_tb_top;
    import srfsd_pkg::*;

    localparam int BITC = 8;
    localparam logic [4:0] MT [8] = '{
        {MODE_STDBY, MODE_SLEEP, 1'b1}, {MODE_SLEEP, MODE_STDBY, 1'b1},
        {MODE_SLEEP, MODE_TX, 1'b1}, {MODE_TX, MODE_STDBY, 1'b0},
        {MODE_STDBY, MODE_TX, 1'b1}, {MODE_TX, MODE_SLEEP, 1'b0},
        {MODE_STDBY, MODE_RX, 1'b0}, {MODE_SLEEP, MODE_RX, 1'b0}};
    logic core_clk, spi_miso, spi_miso_oe, mod_data, frame_sent_flag, pattern_match_flag;
    logic rstn = 1'b0, packet_mode = 1'b0, bitsync_enable = 1'b0;
    logic demod_clk = 1'b0, demod_data = 1'b0;
    wire spi_sck, spi_nss, spi_mosi, spi_miso_w;
    srfsd_mode_t op_mode = MODE_STDBY;
    srfsd_qstat_t queue_status;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed;
    logic [7:0] pat [8];
    logic [7:0] q_exp[$];
    logic [7:0] v, w;
    logic [15:0] got;

    assign spi_miso_w = spi_miso_oe ? spi_miso : 1'bz;

    srfsd_top #(.BIT_CYCLES(BITC)) u_dut (.*);
    srfsd_host u_host (.*);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Hang guard, about one and a half times the expected run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ------
    // Tasks and expectations
    // ------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] flags(input logic l, o, s, m, f, e);
        return {2'b00, l, o, s, m, f, e};
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.tx_q.push_back(d);
        u_host.frame(1'b1, a, 1);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        u_host.frame(1'b0, a, 1);
        d = u_host.rx_q[0];
    endtask

    task automatic set_mode(input srfsd_mode_t m);
        op_mode <= m;
        u_host.tick(4);
    endtask

    // Modem clock idles between bursts
    task automatic send_bits(input logic [15:0] b);
        #13;
        for (int i = 15; i >= 0; i--) begin
            demod_data <= b[i];
            #160;
            demod_clk <= 1'b1;
            #160;
            demod_clk <= 1'b0;
        end
        demod_data <= ~demod_data;
        u_host.tick(4);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------
    // Main sequence
    // ------
    initial begin
        seed = 32'he156;
        u_host.tick(6);
        rstn <= 1'b1;
        u_host.tick(2);
        check("status", {4'h0, queue_status}, 8'h08);
        u_host.frame(1'b0, PATTERN_CONFIG_ADDR, 2);
        check("cfg reset", u_host.rx_q[0], PATTERN_CONFIG_RESET);
        check("pat reset", u_host.rx_q[1], REG_RESET);
        rd(FLAGS_ADDR, v);
        check("flags reset", v, flags(0, 0, 0, 0, 0, 1));
        $display("reset test done");
        foreach (pat[i]) pat[i] = 8'($random(seed)) | 8'h01;
        for (int r = 0; r < 2; r++) begin
            foreach (pat[i]) u_host.tx_q.push_back(pat[i]);
            u_host.frame(1'b1, PATTERN_FIRST_BYTE_ADDR, 8);
            foreach (pat[i]) check("old value", u_host.rx_q[i], r ? pat[i] : REG_RESET);
        end
        u_host.frame(1'b0, PATTERN_FIRST_BYTE_ADDR, 8);
        foreach (pat[i]) check("burst read", u_host.rx_q[i], pat[i]);
        $display("burst test done");
        wr(QUEUE_THRESHOLD_ADDR, 8'h02);
        for (int i = 0; i <= QUEUE_DEPTH; i++) begin
            v = 8'($random(seed));
            u_host.tx_q.push_back(v);
            q_exp.push_back(v);
        end
        u_host.frame(1'b1, FIFO_ADDR, QUEUE_DEPTH + 1);
        rd(FLAGS_ADDR, v);
        check("flags full", v, flags(1, 1, 0, 0, 1, 0));
        u_host.frame(1'b0, FIFO_ADDR, QUEUE_DEPTH);
        for (int i = 0; i < QUEUE_DEPTH; i++) check("queue", u_host.rx_q[i], q_exp[i]);
        rd(FLAGS_ADDR, v);
        check("flags drained", v, flags(0, 1, 0, 0, 0, 1));
        repeat (3) wr(FIFO_ADDR, 8'h5a);
        wr(QUEUE_THRESHOLD_ADDR, 8'h05);
        rd(FLAGS_ADDR, v);
        check("level kept", v, flags(1, 1, 0, 0, 0, 0));
        wr(FIFO_ADDR, 8'ha5);
        rd(FLAGS_ADDR, v);
        check("level update", v, flags(0, 1, 0, 0, 0, 0));
        wr(FLAGS_ADDR, 8'h10);
        rd(FLAGS_ADDR, v);
        check("overrun clear", v, flags(0, 0, 0, 0, 0, 1));
        $display("queue test done");
        for (int i = 0; i < 8; i++) begin
            set_mode(srfsd_mode_t'(MT[i][4:3]));
            wr(FIFO_ADDR, 8'h3c);
            set_mode(srfsd_mode_t'(MT[i][2:1]));
            rd(FLAGS_ADDR, v);
            check("mode clear", {7'h00, v[0]}, {7'h00, ~MT[i][0]});
        end
        $display("mode test done");
        set_mode(MODE_STDBY);
        packet_mode <= 1'b1;
        v = 8'($random(seed));
        w = 8'($random(seed));
        wr(FIFO_ADDR, v);
        wr(FIFO_ADDR, w);
        op_mode <= MODE_TX;
        u_host.tick(6);
        for (int i = 15; i >= 0; i--) begin
            got[i] = mod_data;
            if (i == 8) check("sent early", {7'h00, frame_sent_flag}, 8'h00);
            u_host.tick(BITC);
        end
        check("tx first", got[15:8], v);
        check("tx second", got[7:0], w);
        u_host.tick(4);
        check("sent", {7'h00, frame_sent_flag}, 8'h01);
        set_mode(MODE_STDBY);
        $display("transmit test done");
        wr(PATTERN_CONFIG_ADDR, 8'h11);
        for (int i = 0; i < 3; i++) begin
            packet_mode <= (i == 2);
            bitsync_enable <= (i == 1);
            set_mode(MODE_STDBY);
            set_mode(MODE_RX);
            send_bits({pat[0], pat[1] ^ 8'h01});
            check("near miss", {7'h00, pattern_match_flag}, 8'h00);
            send_bits({pat[0], pat[1]});
            check("match", {7'h00, pattern_match_flag}, {7'h00, i != 0});
        end
        v = 8'($random(seed));
        w = 8'($random(seed));
        send_bits({v, w});
        u_host.frame(1'b0, FIFO_ADDR, 2);
        check("rx first", u_host.rx_q[0], v);
        check("rx second", u_host.rx_q[1], w);
        check("match cleared", {7'h00, pattern_match_flag}, 8'h00);
        $display("recognizer test done");
        give_verdict();
    end
endmodule // srfsd_tb_top
